/* design/sram_burst_device.sv */
// Purpose: synchronous pipelined burst static RAM, control and burst address logic
// Assumes: x36 organisation; rst stands in for power-up
// Notes: output enable and snooze act without the clock
//
// Behaviour
// - controller wires seed bits to address lsbs
// - each lane stores one parity bit
// - write when global, or gate plus lane
// - lane write touches only its byte, parity
// - four lanes a to d with parity
// - inputs sampled on rising edge, except two
// - controller suspends burst for wait states
// - controller parks output enable before writes
// - data pins released from power-up
// - processor strobe starts a read when chip enable is low, even with write
// - write follows processor start next edge
// - controller strobe begins read or write
// - advance low steps burst; enable high ignores
// - advance high repeats current address
// - read data driven only with enable
// - order input picks linear or interleaved
// - interleaved order xors seed with beat
`default_nettype none

module sram_burst_device
	import sram_burst_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// ram pins
	sram_port_if.device pins,
	// observation
	output logic poweredDown,
	output logic [ADDR_W-1:0] accessAddrOut
);
	// four lanes, each a byte plus parity
	logic [WORD_W-1:0] mem [MEM_DEPTH];

	logic [ADDR_W-SEED_W-1:0] baseHigh_q;
	logic [SEED_W-1:0] seed_q;
	logic [SEED_W-1:0] beat_q;
	logic procStart_q;
	logic readActive_q;
	logic deselected_q;
	logic [WORD_W-1:0] readWord_q;

	logic writeQual;
	logic [LANES-1:0] laneEn;
	logic selected;
	logic deselect;
	burst_op_e op;
	logic holdForWrite;
	logic doWrite;
	logic doRead;
	logic [SEED_W-1:0] nextBeat;
	logic [ADDR_W-1:0] accessAddr;
	logic [WORD_W-1:0] pinWord;
	logic [WORD_W-1:0] mergedWord;
	logic live;

	// ----------------------------------------------------------------
	// write qualifier and lane gating
	// ----------------------------------------------------------------
	always_comb begin
		// global write or gated lane write
		writeQual = ~pins.allLanesWriteN | (~pins.laneWriteGateN & ~(&pins.laneWriteN));
		// global forces all lanes, else own lane
		laneEn = pins.allLanesWriteN ? (pins.laneWriteGateN ? '0 : ~pins.laneWriteN) : '1;
	end

	assign pinWord = {pins.dataLanes, pins.laneParity};

	// merge selected bytes and parity bits
	always_comb begin
		mergedWord = mem[accessAddr];
		for (int i = 0; i < LANES; i++) begin
			if (laneEn[i]) begin
				mergedWord[LANES + i*LANE_BITS +: LANE_BITS] =
					pinWord[LANES + i*LANE_BITS +: LANE_BITS];
				mergedWord[i] = pinWord[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// operation decode
	// ----------------------------------------------------------------
	always_comb begin
		selected = ~pins.chipEnableN & ~pins.secondarySelectN & pins.secondarySelect;
		deselect = (pins.chipEnableN & ~pins.ctrlAddrStrobeN) |
			(~pins.chipEnableN & (pins.secondarySelectN | ~pins.secondarySelect) &
			(~pins.procAddrStrobeN | ~pins.ctrlAddrStrobeN));
		if (deselect) begin
			op = OP_DESELECT;
		end else if (selected && !pins.procAddrStrobeN) begin
			op = OP_READ_BEGIN;
		end else if (selected && !pins.ctrlAddrStrobeN) begin
			op = writeQual ? OP_WRITE_BEGIN : OP_READ_BEGIN;
		end else if (!pins.burstAdvanceN) begin
			op = OP_CONTINUE;
		end else begin
			op = OP_SUSPEND;
		end
	end

	// ----------------------------------------------------------------
	// burst address
	// ----------------------------------------------------------------
	always_comb begin
		// write after processor start stays put
		holdForWrite = procStart_q & writeQual;
		nextBeat = (op == OP_CONTINUE && !holdForWrite) ? SEED_W'(beat_q + 1'b1) : beat_q;
		if (op == OP_READ_BEGIN || op == OP_WRITE_BEGIN) begin
			accessAddr = {pins.addrHigh, pins.burstSeedBits};
		end else begin
			accessAddr = {baseHigh_q, burstLow(pins.burstOrder, seed_q, nextBeat)};
		end
		doWrite = (op == OP_WRITE_BEGIN) ||
			((op == OP_CONTINUE || op == OP_SUSPEND) && writeQual);
		doRead = (op == OP_READ_BEGIN) ||
			((op == OP_CONTINUE || op == OP_SUSPEND) && !writeQual);
	end

	assign live = ~pins.snoozeIn;

	// all controls except output enable and snooze taken at the rising edge
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			baseHigh_q <= '0;
			seed_q <= SEED_RESET;
			beat_q <= SEED_RESET;
		end else if (live) begin
			if (op == OP_READ_BEGIN || op == OP_WRITE_BEGIN) begin
				baseHigh_q <= pins.addrHigh;
				seed_q <= pins.burstSeedBits;
				beat_q <= SEED_RESET;
			end else if (op != OP_DESELECT) begin
				beat_q <= nextBeat;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			procStart_q <= 1'b0;
		end else if (live) begin
			procStart_q <= selected & ~deselect & ~pins.procAddrStrobeN;
		end
	end

	// ----------------------------------------------------------------
	// array and read pipeline
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (live && op != OP_DESELECT && doWrite) begin
			mem[accessAddr] <= mergedWord;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			readWord_q <= WORD_RESET;
		end else if (live && op != OP_DESELECT && doRead) begin
			readWord_q <= mem[accessAddr];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			readActive_q <= 1'b0;
			deselected_q <= 1'b1;
		end else if (live) begin
			readActive_q <= (op != OP_DESELECT) & doRead;
			deselected_q <= op == OP_DESELECT;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			accessAddrOut <= ADDR_RESET;
		end else if (live && op != OP_DESELECT) begin
			accessAddrOut <= accessAddr;
		end
	end

	// ----------------------------------------------------------------
	// data pins
	// ----------------------------------------------------------------
	// drive only with enable low, awake
	assign pins.devDataOe = readActive_q & ~pins.outEnableN & ~pins.snoozeIn;
	assign pins.devDataLanes = readWord_q[WORD_W-1:LANES];
	assign pins.devLaneParity = readWord_q[LANES-1:0];
	assign poweredDown = deselected_q | pins.snoozeIn;

endmodule : sram_burst_device

`default_nettype wire

/* design/sram_burst_pkg.sv */
// Purpose: shared constants and types for the burst static RAM pin interface
// Assumes: one clock, x36 organisation (four byte lanes, each with a parity bit)
// Notes: all ends and the pin interface import this package
`default_nettype none

package sram_burst_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 19;
	localparam int SEED_W = 2;
	localparam int LANES = 4;
	localparam int LANE_BITS = 8;
	localparam int DATA_W = LANES * LANE_BITS;
	localparam int WORD_W = DATA_W + LANES;
	localparam int MEM_DEPTH = 1 << ADDR_W;
	localparam int FIFO_DEPTH = 8;
	localparam int REQ_W = 1 + ADDR_W + WORD_W + LANES;

	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic [SEED_W-1:0] SEED_RESET = 2'h0;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h00000;
	localparam logic [WORD_W-1:0] WORD_RESET = 36'h000000000;
	localparam logic [LANES-1:0] LANES_OFF_N = 4'hf;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_DESELECT,
		OP_READ_BEGIN,
		OP_WRITE_BEGIN,
		OP_CONTINUE,
		OP_SUSPEND
	} burst_op_e;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ISSUE,
		ST_READ
	} ctrl_state_e;

	// linear order adds the beat count, interleaved order xors it
	function automatic logic [SEED_W-1:0] burstLow(input logic interleaved,
			input logic [SEED_W-1:0] seed, input logic [SEED_W-1:0] beat);
		burstLow = interleaved ? (seed ^ beat) : SEED_W'(seed + beat);
	endfunction : burstLow

endpackage : sram_burst_pkg

`default_nettype wire

/* design/sram_port_if.sv */
// Purpose: pin bundle between the burst RAM and its memory controller
// Assumes: both ends run on core_clk
// Notes: the shared data pins are resolved here from the two drive enables
`default_nettype none

interface sram_port_if;
	import sram_burst_pkg::*;

	// address and control, driven by the controller
	logic [ADDR_W-SEED_W-1:0] addrHigh;
	logic [SEED_W-1:0] burstSeedBits;
	logic chipEnableN;
	logic secondarySelect;
	logic secondarySelectN;
	logic procAddrStrobeN;
	logic ctrlAddrStrobeN;
	logic burstAdvanceN;
	logic [LANES-1:0] laneWriteN;
	logic laneWriteGateN;
	logic allLanesWriteN;
	logic outEnableN;
	logic snoozeIn;
	logic burstOrder;
	// data, each end drives its own copy
	logic [DATA_W-1:0] ctlDataLanes;
	logic [LANES-1:0] ctlLaneParity;
	logic ctlDataOe;
	logic [DATA_W-1:0] devDataLanes;
	logic [LANES-1:0] devLaneParity;
	logic devDataOe;
	// resolved pin level
	logic [DATA_W-1:0] dataLanes;
	logic [LANES-1:0] laneParity;
	logic busClash;

	assign dataLanes = devDataOe ? devDataLanes : (ctlDataOe ? ctlDataLanes : '0);
	assign laneParity = devDataOe ? devLaneParity : (ctlDataOe ? ctlLaneParity : '0);
	assign busClash = devDataOe & ctlDataOe;

	modport device (
		input addrHigh, burstSeedBits, chipEnableN, secondarySelect, secondarySelectN,
		input procAddrStrobeN, ctrlAddrStrobeN, burstAdvanceN, laneWriteN,
		input laneWriteGateN, allLanesWriteN, outEnableN, snoozeIn, burstOrder,
		input dataLanes, laneParity,
		output devDataLanes, devLaneParity, devDataOe
	);

	modport ctrl (
		output addrHigh, burstSeedBits, chipEnableN, secondarySelect, secondarySelectN,
		output procAddrStrobeN, ctrlAddrStrobeN, burstAdvanceN, laneWriteN,
		output laneWriteGateN, allLanesWriteN, outEnableN, snoozeIn, burstOrder,
		input dataLanes, laneParity,
		output ctlDataLanes, ctlLaneParity, ctlDataOe
	);

endinterface : sram_port_if

`default_nettype wire

/* design/req_fifo.sv */
// Purpose: synchronous FIFO with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes: full and empty come from a count, so the last slot is usable
`default_nettype none

module req_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] slots [DEPTH];
	logic [PTR_W-1:0] wrPtr_q;
	logic [PTR_W-1:0] rdPtr_q;
	logic [PTR_W:0] count_q;
	logic push;
	logic pop;

	assign inReady = count_q != (PTR_W+1)'(DEPTH);
	assign outValid = count_q != '0;
	assign outData = slots[rdPtr_q];
	assign push = inValid & inReady;
	assign pop = outValid & outReady;

	always_ff @(posedge core_clk) begin
		if (push) begin
			slots[wrPtr_q] <= inData;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
			count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		end
	end

endmodule : req_fifo

`default_nettype wire

/* design/sram_burst_ctrl.sv */
// Purpose: memory controller end: turns queued requests into single RAM accesses
// Assumes: the RAM samples every control pin except output enable and snooze on the same core_clk edge
// Notes: reads take three cycles, writes two; idle cycles deselect the RAM
`default_nettype none

module sram_burst_ctrl
	import sram_burst_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// request stream
	input wire logic reqValid,
	output logic reqReady,
	input wire logic reqWrite,
	input wire logic [ADDR_W-1:0] reqAddr,
	input wire logic [WORD_W-1:0] reqData,
	input wire logic [LANES-1:0] reqLanes,
	// read answers
	output logic rspValid,
	output logic [WORD_W-1:0] rspData,
	// static order choice and sleep request
	input wire logic burstOrderSel,
	input wire logic sleepReq,
	// ram pins
	sram_port_if.ctrl pins
);
	ctrl_state_e state_q;
	logic qValid;
	logic qPop;
	logic [REQ_W-1:0] qData;
	logic qWrite;
	logic [ADDR_W-1:0] qAddr;
	logic [WORD_W-1:0] qWord;
	logic [LANES-1:0] qLanes;
	logic issueWrite_q;

	// ----------------------------------------------------------------
	// request queue
	// ----------------------------------------------------------------
	req_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) queue (
		.core_clk(core_clk),
		.rst(rst),
		.inValid(reqValid),
		.inReady(reqReady),
		.inData({reqWrite, reqAddr, reqData, reqLanes}),
		.outValid(qValid),
		.outReady(qPop),
		.outData(qData)
	);

	assign {qWrite, qAddr, qWord, qLanes} = qData;
	assign qPop = qValid & (state_q == ST_IDLE) & ~sleepReq & ~pins.snoozeIn;

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			issueWrite_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (qPop) begin
						state_q <= ST_ISSUE;
						issueWrite_q <= qWrite;
					end
				end
				ST_ISSUE: begin
					state_q <= issueWrite_q ? ST_IDLE : ST_READ;
				end
				ST_READ: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pins.addrHigh <= '0;
			pins.burstSeedBits <= SEED_RESET;
			pins.chipEnableN <= 1'b1;
			pins.ctrlAddrStrobeN <= 1'b0;
			pins.burstAdvanceN <= 1'b1;
			pins.laneWriteN <= LANES_OFF_N;
			pins.laneWriteGateN <= 1'b1;
			pins.outEnableN <= 1'b1;
			pins.ctlDataLanes <= '0;
			pins.ctlLaneParity <= '0;
			pins.ctlDataOe <= 1'b0;
		end else begin
			// default: deselect with enable high and controller strobe low
			pins.chipEnableN <= 1'b1;
			pins.ctrlAddrStrobeN <= 1'b0;
			pins.burstAdvanceN <= 1'b1;
			pins.laneWriteN <= LANES_OFF_N;
			pins.laneWriteGateN <= 1'b1;
			pins.outEnableN <= 1'b1;
			pins.ctlDataOe <= 1'b0;
			if (qPop) begin
				pins.addrHigh <= qAddr[ADDR_W-1:SEED_W];
				pins.burstSeedBits <= qAddr[SEED_W-1:0];
				pins.chipEnableN <= 1'b0;
				pins.laneWriteGateN <= ~qWrite;
				pins.laneWriteN <= qWrite ? ~qLanes : LANES_OFF_N;
				pins.ctlDataLanes <= qWord[WORD_W-1:LANES];
				pins.ctlLaneParity <= qWord[LANES-1:0];
				pins.ctlDataOe <= qWrite;
			end else if (state_q == ST_ISSUE && !issueWrite_q) begin
				pins.ctrlAddrStrobeN <= 1'b1;
				pins.burstAdvanceN <= 1'b1;
				// output enable only in read slot
				pins.outEnableN <= 1'b0;
			end
		end
	end

	assign pins.procAddrStrobeN = 1'b1;
	assign pins.secondarySelect = 1'b1;
	assign pins.secondarySelectN = 1'b0;
	assign pins.allLanesWriteN = 1'b1;
	assign pins.burstOrder = burstOrderSel;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pins.snoozeIn <= 1'b0;
		end else begin
			pins.snoozeIn <= sleepReq & (state_q == ST_IDLE) & ~qPop;
		end
	end

	// ----------------------------------------------------------------
	// read answer
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rspValid <= 1'b0;
			rspData <= WORD_RESET;
		end else begin
			rspValid <= state_q == ST_READ;
			if (state_q == ST_READ) begin
				rspData <= {pins.dataLanes, pins.laneParity};
			end
		end
	end

endmodule : sram_burst_ctrl

`default_nettype wire

/* bench/sram_burst_props.sv */
// Purpose: concurrent checks on the pins between burst RAM and controller
// Assumes: one clock domain, rst asynchronous and active high
// Notes: instantiated beside the first pin bundle in tb_top
`default_nettype none

module sram_burst_props (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// control pins
	input wire logic chipEnableN,
	input wire logic procAddrStrobeN,
	input wire logic ctrlAddrStrobeN,
	input wire logic laneWriteGateN,
	input wire logic allLanesWriteN,
	input wire logic outEnableN,
	input wire logic snoozeIn,
	// data drive
	input wire logic devDataOe,
	input wire logic ctlDataOe,
	input wire logic busClash
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// ----------------------------------------------------------------
	// access kinds
	// ----------------------------------------------------------------
	sequence s_readBegin;
		!chipEnableN && procAddrStrobeN && !ctrlAddrStrobeN && laneWriteGateN && allLanesWriteN
			&& !snoozeIn;
	endsequence

	sequence s_writeBegin;
		!chipEnableN && !ctrlAddrStrobeN && !laneWriteGateN && !snoozeIn;
	endsequence

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_reset_release: assert property ($fell(rst) |-> !devDataOe && !ctlDataOe)
		else $error("data pins driven right after reset");
	a_read_drives: assert property (s_readBegin ##1 !outEnableN |-> devDataOe)
		else $error("read begin did not drive data");
	a_oe_gates: assert property (outEnableN |-> !devDataOe)
		else $error("data driven with output enable high");
	a_snooze_release: assert property (snoozeIn |-> !devDataOe)
		else $error("data driven in snooze");
	a_no_clash: assert property (!busClash)
		else $error("both ends drive the data pins");
	a_write_quiet: assert property (s_writeBegin |=> !devDataOe)
		else $error("device drove data after a write");
	a_deselect_release: assert property (chipEnableN && !ctrlAddrStrobeN |=> !devDataOe)
		else $error("data driven after deselect");
	a_oe_before_write: assert property (s_writeBegin |-> outEnableN && $past(outEnableN))
		else $error("output enable low around write data");
	a_drive_after_read: assert property (devDataOe |-> $past(laneWriteGateN) && $past(allLanesWriteN))
		else $error("data driven after a write access");

endmodule : sram_burst_props

`default_nettype wire

/* bench/tb_top.sv */
// Purpose: drives both ends of the burst RAM link and checks results
// Assumes: 25 MHz core_clk, inputs driven at the falling edge
// Notes: a second RAM end is driven pin by pin for burst and strobe cases
`default_nettype none

module tb_top
	import sram_burst_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// pin patterns: {ceN, procN, ctrlN, advN, allWrN, oeN, drive, snooze}
	localparam logic [7:0] P_BEGIN = 8'h58, P_CONT = 8'h68, P_SUSP = 8'h78, P_CONT_CE = 8'ha8;
	localparam logic [7:0] P_PRD_W = 8'h30, P_WR_NEXT = 8'h76, P_PRD = 8'h38, P_PRD_HIZ = 8'h3c;
	localparam logic [7:0] P_DESEL = 8'hd8, P_SNOOZE = 8'h59;
	localparam logic [ADDR_W-1:0] ADDR_B = 19'h2a5a5, BASE = 19'h01235;

	logic core_clk, rst, reqValid, reqReady, reqWrite, rspValid, burstOrderSel, sleepReq;
	logic poweredDown, poweredDownB;
	logic [ADDR_W-1:0] reqAddr, accessAddrOut, accessAddrB;
	logic [WORD_W-1:0] reqData, rspData, mem [32];
	logic [LANES-1:0] reqLanes;
	logic [1:0] beat, low;
	int nFail = 0;
	int numChecks = 0;

	sram_port_if pins ();
	sram_port_if pinsB ();

	sram_burst_ctrl i_sram_burst_ctrl (.core_clk(core_clk), .rst(rst), .reqValid(reqValid),
		.reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
		.reqLanes(reqLanes), .rspValid(rspValid), .rspData(rspData),
		.burstOrderSel(burstOrderSel), .sleepReq(sleepReq), .pins(pins.ctrl));
	sram_burst_device i_sram_burst_device (.core_clk(core_clk), .rst(rst), .pins(pins.device),
		.poweredDown(poweredDown), .accessAddrOut(accessAddrOut));
	sram_burst_device i_sram_burst_device_b (.core_clk(core_clk), .rst(rst),
		.pins(pinsB.device), .poweredDown(poweredDownB), .accessAddrOut(accessAddrB));
	sram_burst_props i_sram_burst_props (.core_clk(core_clk), .rst(rst),
		.chipEnableN(pins.chipEnableN), .procAddrStrobeN(pins.procAddrStrobeN),
		.ctrlAddrStrobeN(pins.ctrlAddrStrobeN), .laneWriteGateN(pins.laneWriteGateN),
		.allLanesWriteN(pins.allLanesWriteN), .outEnableN(pins.outEnableN),
		.snoozeIn(pins.snoozeIn), .devDataOe(pins.devDataOe), .ctlDataOe(pins.ctlDataOe),
		.busClash(pins.busClash));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic end_sim();
		if (nFail == 0 && numChecks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
		numChecks++;
		if (got !== exp) begin
			nFail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [WORD_W-1:0] laneMask(input logic [LANES-1:0] l);
		laneMask = '0;
		for (int i = 0; i < LANES; i++) begin
			if (l[i]) laneMask |= (WORD_W'(8'hff) << (LANES + 8 * i)) | (WORD_W'(1) << i);
		end
	endfunction : laneMask

	task automatic push(input logic w, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d,
			input logic [LANES-1:0] l);
		int n;
		@(negedge core_clk);
		{reqValid, reqWrite, reqAddr, reqData, reqLanes} = {1'b1, w, a, d, l};
		for (n = 0; n < 50 && reqReady !== 1'b1; n++) @(negedge core_clk);
		if (n == 50) begin
			nFail++;
			end_sim();
		end
		if (w) mem[a[4:0]] = (mem[a[4:0]] & ~laneMask(l)) | (d & laneMask(l));
		@(negedge core_clk);
		reqValid = 1'b0;
	endtask : push

	task automatic rd(input logic [ADDR_W-1:0] a);
		int n;
		push(1'b0, a, '0, '0);
		for (n = 0; n < 50 && rspValid !== 1'b1; n++) @(negedge core_clk);
		if (n == 50) begin
			nFail++;
			end_sim();
		end
		chk(rspData, mem[a[4:0]]);
	endtask : rd

	// one cycle on the second pin bundle, entered at a falling edge
	task automatic pcyc(input logic [7:0] c, input logic [ADDR_W-1:0] a);
		{pinsB.chipEnableN, pinsB.procAddrStrobeN, pinsB.ctrlAddrStrobeN, pinsB.burstAdvanceN,
			pinsB.allLanesWriteN, pinsB.outEnableN, pinsB.ctlDataOe, pinsB.snoozeIn} = c;
		{pinsB.addrHigh, pinsB.burstSeedBits} = a;
		@(posedge core_clk);
		@(negedge core_clk);
	endtask : pcyc

	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	initial begin
		rst = 1'b1;
		{reqValid, reqWrite, reqAddr, reqData, reqLanes, sleepReq} = '0;
		burstOrderSel = 1'b1;
		{pinsB.secondarySelect, pinsB.secondarySelectN, pinsB.laneWriteN, pinsB.laneWriteGateN} = 7'h5f;
		{pinsB.ctlDataLanes, pinsB.ctlLaneParity} = 36'h3c5a96e19;
		pinsB.burstOrder = 1'b1;
		pcyc(P_DESEL, '0);
		repeat (5) @(negedge core_clk);
		chk(WORD_W'({pins.devDataOe, pinsB.devDataOe, poweredDown}), 36'h1);
		rst = 1'b0;
		for (int i = 0; i < LANES; i++) begin
			push(1'b1, ADDR_W'(i), 36'h876543219, 4'hf);
			push(1'b1, ADDR_W'(i), 36'h789abcde6, 4'h1 << i);
			push(1'b1, ADDR_W'(i), 36'h0, 4'h0);
			rd(ADDR_W'(i));
		end
		@(negedge core_clk);
		sleepReq = 1'b1;
		repeat (4) @(negedge core_clk);
		chk(WORD_W'({poweredDown, pins.snoozeIn}), 36'h3);
		for (int i = 0; i < FIFO_DEPTH; i++) push(1'b1, ADDR_W'(8 + i), 36'h5a5a5a5a0 + WORD_W'(i), 4'hf);
		chk(WORD_W'(reqReady), 36'h0);
		sleepReq = 1'b0;
		for (int i = 0; i < FIFO_DEPTH; i++) rd(ADDR_W'(8 + i));
		pcyc(P_PRD_W, ADDR_B);
		chk(WORD_W'({pinsB.devDataOe, accessAddrB}), WORD_W'({1'b1, ADDR_B}));
		pcyc(P_WR_NEXT, '0);
		pcyc(P_PRD, ADDR_B);
		chk({pinsB.dataLanes, pinsB.laneParity}, 36'h3c5a96e19);
		pcyc(P_PRD_HIZ, ADDR_B);
		chk(WORD_W'(pinsB.devDataOe), 36'h0);
		pcyc(P_DESEL, ADDR_B);
		chk(WORD_W'({pinsB.devDataOe, poweredDownB}), 36'h1);
		pcyc(P_SNOOZE, '0);
		chk(WORD_W'({pinsB.devDataOe, poweredDownB, accessAddrB}), WORD_W'({2'h1, ADDR_B}));
		for (int o = 0; o < 2; o++) begin
			pinsB.burstOrder = o[0];
			pcyc(P_BEGIN, BASE);
			chk(WORD_W'(accessAddrB), WORD_W'(BASE));
			for (int b = 1; b < 6; b++) begin
				pcyc(b == 3 ? P_SUSP : (b == 4 ? P_CONT_CE : P_CONT), '0);
				beat = 2'(b - int'(b > 2));
				low = o[0] ? (BASE[1:0] ^ beat) : 2'(BASE[1:0] + beat);
				chk(WORD_W'(accessAddrB), WORD_W'({BASE[ADDR_W-1:2], low}));
			end
		end
		end_sim();
	end

endmodule : tb_top

`default_nettype wire
